// ---- hw/rsc_pkg.sv ----
package rsc_pkg;
   // How it works
   // - Execution waits for power-up timer, oscillator start-up timer and pin release, each when enabled.
   // - Both start-up timers keep counting while the external reset pin is held low.
   // - After pin release with timers expired, execution starts exactly 11 clocks later.
   // - Every reset updates the cause register; only supply, watchdog and in-sleep pin resets also update the status register.
   // - Cause register has seven flags for the eight reset causes.
   // - Resets load program counter 0000h; sleep wake-ups continue at the next address.
   // - Interrupt wake with global enable runs next instruction, then pushes and vectors to 0004h.
   // - Timeout and sleep flags: set on power-on, changed per watchdog, interrupt and pin events.
   // - Bit 7 set by stack overflow reset, cleared by firmware or brown-out, zero on power-on.
   // - Stack fault resets and their flags only when the stack fault enable is 1.
   // - Bit 4 cleared by a watchdog reset; firmware may set it again.
   // - Bit 2 cleared by the reset instruction; firmware may set it again.
   // - Bit 1 cleared by power-on reset; firmware sets it afterwards.
   // - Power-up timer holds reset for 64 ms, starting after supply monitors release.
   // - Crystal mode start-up timer counts 1024 oscillator cycles after power-up or wake.
   // - Brown-out and low-power brown-out share one brown-out flag; power-on has its own flag.

   // Clock and timing
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned POWER_UP_MS     = 64;
   localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
   localparam int unsigned OSC_START_TICKS = 1024;
   localparam logic [3:0]  START_DELAY    = 4'ha;

   // Program counter targets
   localparam logic [15:0] PC_RESET_VEC = 16'h0000;
   localparam logic [15:0] PC_IRQ_VEC   = 16'h0004;

   // Wishbone register byte offsets
   localparam int unsigned ADR_W      = 4;
   localparam logic [3:0]  REG_CAUSE  = 4'h0;
   localparam logic [3:0]  REG_STATUS = 4'h4;
   localparam logic [3:0]  REG_CONFIG = 4'h8;
   localparam logic [3:0]  REG_SEQ    = 4'hc;

   // Reset cause register layout
   typedef struct packed {
      logic stack_over_flag;
      logic stack_under_flag;
      logic unused5;
      logic watchdog_cause_flag;
      logic ext_pin_cause_flag;
      logic soft_reset_opcode_flag;
      logic power_on_cause_flag;
      logic brownout_cause_flag;
   } rsc_cause_t;

   // Core status register layout, low and high bits belong to the core
   typedef struct packed {
      logic [2:0] core_hi;
      logic       timeout_status_flag;
      logic       sleep_status_flag;
      logic [2:0] core_lo;
   } rsc_status_t;

   // Start-up configuration
   typedef struct packed {
      logic [3:0] rsvd;
      logic       stack_fault_reset_enable;
      logic       osc_needs_start;
      logic       ext_pin_enable;
      logic       power_up_timer_enable;
   } rsc_config_t;

   localparam rsc_cause_t  CAUSE_POWER_ON  = 8'h1c;
   localparam rsc_status_t STATUS_POWER_ON = 8'h18;
   localparam rsc_config_t CONFIG_RESET    = 8'h0f;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_SUPPLY,
      ST_POWER_UP,
      ST_OSC_START,
      ST_PIN,
      ST_DELAY,
      ST_RUN,
      ST_SLEEP,
      ST_WAKE_OSC
   } rsc_state_t;
endpackage : rsc_pkg

// ---- hw/rsc_tick.sv ----
`timescale 1ns/10ps
module rsc_tick #(
   parameter int unsigned DIV = 25000
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic clr_i,
   output logic      tick_o
);
   localparam int unsigned W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_r;

   // Free divider, restarted by clr_i
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         cnt_r  <= '0;
         tick_o <= 1'b0;
      end else if (cnt_r == LAST) begin
         cnt_r  <= '0;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule : rsc_tick

// ---- hw/rsc_timer.sv ----
`timescale 1ns/10ps
module rsc_timer #(
   parameter int unsigned LIMIT = 64
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic start_i,
   input  wire logic en_i,
   output logic      done_o
);
   localparam int unsigned W = $clog2(LIMIT + 1);
   localparam logic [W-1:0] LAST = W'(LIMIT - 1);

   logic [W-1:0] cnt_r;

   // Held clear while start_i, counts en_i pulses, then latches done
   always_ff @(posedge clk_i) begin
      if (rst_i || start_i) begin
         cnt_r  <= '0;
         done_o <= 1'b0;
      end else if (en_i && !done_o) begin
         cnt_r <= cnt_r + 1'b1;
         if (cnt_r == LAST) begin
            done_o <= 1'b1;
         end
      end
   end
endmodule : rsc_timer

// ---- hw/rsc_seq.sv ----
`timescale 1ns/10ps
module rsc_seq
   import rsc_pkg::*;
#(
   parameter int unsigned MS_DIV          = MS_CYCLES,
   parameter int unsigned POWER_UP_COUNT  = POWER_UP_MS,
   parameter int unsigned OSC_START_COUNT = OSC_START_TICKS
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // Supply monitors and pin
   input  wire logic             por_i,
   input  wire logic             brownout_i,
   input  wire logic             low_power_brownout_detector_i,
   input  wire logic             external_reset_pin_n_i,
   input  wire logic             osc_tick_i,
   // Core side events
   input  wire logic             wdt_timeout_i,
   input  wire logic             clrwdt_i,
   input  wire logic             sleep_enter_i,
   input  wire logic             irq_wake_i,
   input  wire logic             global_irq_enable_i,
   input  wire logic             insn_done_i,
   input  wire logic             soft_reset_i,
   input  wire logic             stack_over_i,
   input  wire logic             stack_under_i,
   // Core control
   output logic                  core_reset_o,
   output logic                  cpu_run_o,
   output logic                  pc_load_o,
   output logic      [15:0]      pc_value_o,
   output logic                  irq_push_o
);

   rsc_state_t  state_r;
   rsc_state_t  state_nxt;
   rsc_cause_t  cause_r;
   rsc_cause_t  cause_nxt;
   rsc_status_t status_r;
   rsc_status_t status_nxt;
   rsc_config_t cfg_r;
   logic [3:0]  delay_r;
   logic        irq_pend_r;
   logic        ms_tick;
   logic        power_up_done;
   logic        osc_start_done;
   logic        supply_low;
   logic        brown_low;
   logic        pin_held;
   logic        in_run;
   logic        in_sleep;
   logic        ev_pin_run;
   logic        ev_pin_sleep;
   logic        ev_wdt_rst;
   logic        ev_wdt_wake;
   logic        ev_irq_wake;
   logic        ev_ovf;
   logic        ev_unf;
   logic        ev_soft;
   logic        ev_sleep;
   logic        ev_clrwdt;
   logic        ev_vector;
   logic        wb_access;
   logic        wb_wr0;
   logic [31:0] rd_word;

   // Supply and pin conditions
   assign brown_low  = brownout_i | low_power_brownout_detector_i;
   assign supply_low = por_i | brown_low;
   assign pin_held   = cfg_r.ext_pin_enable & ~external_reset_pin_n_i;
   assign in_run     = (state_r == ST_RUN);
   assign in_sleep   = (state_r == ST_SLEEP) || (state_r == ST_WAKE_OSC);

   // Reset and wake events, one per cycle by priority
   assign ev_pin_run   = ~supply_low & in_run & pin_held;
   assign ev_pin_sleep = ~supply_low & in_sleep & pin_held;
   assign ev_wdt_rst   = ~supply_low & in_run & ~pin_held & wdt_timeout_i;
   assign ev_ovf       = ~supply_low & in_run & ~pin_held & ~wdt_timeout_i
                         & cfg_r.stack_fault_reset_enable & stack_over_i;
   assign ev_unf       = ~supply_low & in_run & ~pin_held & ~wdt_timeout_i & ~ev_ovf
                         & cfg_r.stack_fault_reset_enable & stack_under_i;
   assign ev_soft      = ~supply_low & in_run & ~pin_held & ~wdt_timeout_i & ~ev_ovf
                         & ~ev_unf & soft_reset_i;
   assign ev_sleep     = ~supply_low & in_run & ~pin_held & ~wdt_timeout_i & ~ev_ovf
                         & ~ev_unf & ~soft_reset_i & sleep_enter_i;
   assign ev_clrwdt    = ~supply_low & in_run & ~pin_held & ~wdt_timeout_i & ~ev_ovf
                         & ~ev_unf & ~soft_reset_i & ~sleep_enter_i & clrwdt_i;
   assign ev_wdt_wake  = ~supply_low & (state_r == ST_SLEEP) & ~pin_held & wdt_timeout_i;
   assign ev_irq_wake  = ~supply_low & (state_r == ST_SLEEP) & ~pin_held & ~wdt_timeout_i
                         & irq_wake_i;
   assign ev_vector    = in_run & irq_pend_r & insn_done_i & (state_nxt == ST_RUN);

   // Millisecond tick for the power-up timer
   rsc_tick #(
      .DIV(MS_DIV)
   ) u_ms_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .clr_i  (state_r != ST_POWER_UP),
      .tick_o (ms_tick)
   );

   // Power-up timer, runs regardless of the pin; done stays up until the next supply event
   rsc_timer #(
      .LIMIT(POWER_UP_COUNT)
   ) u_power_up_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (state_r == ST_SUPPLY),
      .en_i    (ms_tick),
      .done_o  (power_up_done)
   );

   // Oscillator start-up timer; held clear until power-up expiry or while asleep
   rsc_timer #(
      .LIMIT(OSC_START_COUNT)
   ) u_osc_startup_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (!cfg_r.osc_needs_start || (state_r inside {ST_SUPPLY, ST_POWER_UP, ST_SLEEP})),
      .en_i    (osc_tick_i),
      .done_o  (osc_start_done)
   );

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_SUPPLY: begin
            if (cfg_r.power_up_timer_enable) begin
               state_nxt = ST_POWER_UP;
            end else if (cfg_r.osc_needs_start) begin
               state_nxt = ST_OSC_START;
            end else begin
               state_nxt = ST_PIN;
            end
         end
         ST_POWER_UP: begin
            if (power_up_done) begin
               state_nxt = cfg_r.osc_needs_start ? ST_OSC_START : ST_PIN;
            end
         end
         ST_OSC_START: begin
            if (osc_start_done) begin
               state_nxt = ST_PIN;
            end
         end
         ST_PIN: begin
            if (!pin_held) begin
               state_nxt = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (pin_held) begin
               state_nxt = ST_PIN;
            end else if (delay_r == START_DELAY - 4'h1) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ev_pin_run || ev_wdt_rst || ev_ovf || ev_unf || ev_soft) begin
               state_nxt = ST_PIN;
            end else if (ev_sleep) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (ev_pin_sleep) begin
               state_nxt = ST_PIN;
            end else if (ev_wdt_wake || ev_irq_wake) begin
               state_nxt = cfg_r.osc_needs_start ? ST_WAKE_OSC : ST_RUN;
            end
         end
         ST_WAKE_OSC: begin
            if (ev_pin_sleep) begin
               state_nxt = ST_PIN;
            end else if (osc_start_done) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_SUPPLY;
         end
      endcase
      if (supply_low) begin
         state_nxt = ST_SUPPLY;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_SUPPLY;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Start delay after pin release
   always_ff @(posedge clk_i) begin
      if (rst_i || state_r != ST_DELAY) begin
         delay_r <= 4'h0;
      end else begin
         delay_r <= delay_r + 4'h1;
      end
   end

   // Pending interrupt vector after a wake
   always_ff @(posedge clk_i) begin
      if (rst_i || state_nxt == ST_SUPPLY || state_nxt == ST_PIN) begin
         irq_pend_r <= 1'b0;
      end else if (ev_irq_wake && global_irq_enable_i) begin
         irq_pend_r <= 1'b1;
      end else if (ev_vector) begin
         irq_pend_r <= 1'b0;
      end
   end

   // Core control outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_reset_o <= 1'b1;
         cpu_run_o    <= 1'b0;
         pc_load_o    <= 1'b0;
         pc_value_o   <= PC_RESET_VEC;
         irq_push_o   <= 1'b0;
      end else begin
         core_reset_o <= (state_nxt != ST_RUN) && (state_nxt != ST_SLEEP)
                         && (state_nxt != ST_WAKE_OSC);
         cpu_run_o    <= (state_nxt == ST_RUN);
         pc_load_o    <= 1'b0;
         irq_push_o   <= 1'b0;
         if (state_r == ST_DELAY && state_nxt == ST_RUN) begin
            pc_load_o  <= 1'b1;
            pc_value_o <= PC_RESET_VEC;
         end else if (ev_vector) begin
            pc_load_o  <= 1'b1;
            pc_value_o <= PC_IRQ_VEC;
            irq_push_o <= 1'b1;
         end
      end
   end

   // Cause flags: hardware events win over a firmware write
   always_comb begin
      cause_nxt = cause_r;
      if (wb_wr0 && wb_adr_i == REG_CAUSE) begin
         cause_nxt = rsc_cause_t'(wb_dat_i[7:0]);
      end
      cause_nxt.unused5 = 1'b0;
      if (por_i) begin
         cause_nxt = CAUSE_POWER_ON;
      end else if (brown_low) begin
         cause_nxt.stack_over_flag        = 1'b0;
         cause_nxt.stack_under_flag       = 1'b0;
         cause_nxt.ext_pin_cause_flag     = 1'b1;
         cause_nxt.soft_reset_opcode_flag = 1'b1;
         cause_nxt.brownout_cause_flag    = 1'b0;
      end else begin
         if (ev_wdt_rst) begin
            cause_nxt.watchdog_cause_flag = 1'b0;
         end
         if (ev_pin_run || ev_pin_sleep) begin
            cause_nxt.ext_pin_cause_flag = 1'b0;
         end
         if (ev_soft) begin
            cause_nxt.soft_reset_opcode_flag = 1'b0;
         end
         if (ev_ovf) begin
            cause_nxt.stack_over_flag = 1'b1;
         end
         if (ev_unf) begin
            cause_nxt.stack_under_flag = 1'b1;
         end
      end
   end

   // Cause register, updated in the reset cycle itself
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_r <= CAUSE_POWER_ON;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // Timeout and sleep status flags
   always_comb begin
      status_nxt         = status_r;
      status_nxt.core_hi = 3'h0;
      status_nxt.core_lo = 3'h0;
      if (supply_low) begin
         status_nxt.timeout_status_flag = 1'b1;
         status_nxt.sleep_status_flag   = 1'b1;
      end else if (ev_wdt_rst) begin
         status_nxt.timeout_status_flag = 1'b0;
      end else if (ev_wdt_wake) begin
         status_nxt.timeout_status_flag = 1'b0;
         status_nxt.sleep_status_flag   = 1'b0;
      end else if (ev_irq_wake || ev_pin_sleep || ev_sleep) begin
         status_nxt.timeout_status_flag = 1'b1;
         status_nxt.sleep_status_flag   = 1'b0;
      end else if (ev_clrwdt) begin
         status_nxt.timeout_status_flag = 1'b1;
         status_nxt.sleep_status_flag   = 1'b1;
      end
   end

   // Status register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= STATUS_POWER_ON;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Configuration, kept across device resets
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r <= CONFIG_RESET;
      end else if (wb_wr0 && wb_adr_i == REG_CONFIG) begin
         cfg_r      <= rsc_config_t'(wb_dat_i[7:0]);
         cfg_r.rsvd <= 4'h0;
      end
   end

   // Wishbone decode, single-cycle answer
   assign wb_access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr0    = wb_access & wb_we_i & wb_sel_i[0];

   // Read data mux, unmapped reads as zero
   always_comb begin
      case (wb_adr_i)
         REG_CAUSE:  rd_word = {24'h0, cause_r};
         REG_STATUS: rd_word = {24'h0, status_r};
         REG_CONFIG: rd_word = {24'h0, cfg_r};
         REG_SEQ:    rd_word = {24'h0, pin_held, irq_pend_r, osc_start_done, power_up_done, state_r};
         default:    rd_word = 32'h0;
      endcase
   end

   // Acknowledge and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_access;
         if (wb_access && !wb_we_i) begin
            wb_dat_o <= rd_word;
         end
      end
   end

endmodule : rsc_seq

// ---- dv/rsc_seq_assertions.sv ----
`timescale 1ns/10ps
module rsc_seq_assertions
   import rsc_pkg::*;
(
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic             external_reset_pin_n_i,
   input wire logic             wdt_timeout_i,
   input wire logic             insn_done_i,
   input wire logic             core_reset_o,
   input wire logic             cpu_run_o,
   input wire logic             pc_load_o,
   input wire logic [15:0]      pc_value_o,
   input wire logic             irq_push_o
);
   // One domain, reset masks every check
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Bus answer timing
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   // Start-up and run control
   a_run_exclusive: assert property (cpu_run_o |-> !core_reset_o)
      else $error("core runs while held in reset");
   a_start_delay: assert property ($rose(cpu_run_o) && pc_load_o |-> $past(external_reset_pin_n_i, 11))
      else $error("run started too soon after pin release");
   a_wdt_stops: assert property (cpu_run_o && wdt_timeout_i |=> !cpu_run_o)
      else $error("watchdog did not stop the core");
   // Program counter targets
   a_reset_vector: assert property (pc_load_o && !irq_push_o |-> pc_value_o == PC_RESET_VEC)
      else $error("reset load not at zero");
   a_load_pulse: assert property (pc_load_o |=> !pc_load_o)
      else $error("load longer than one cycle");
   a_irq_vector: assert property (irq_push_o |-> pc_load_o && pc_value_o == PC_IRQ_VEC && $past(insn_done_i))
      else $error("bad interrupt vector load");
   // Cause register read-back
   a_bit_five_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == REG_CAUSE |-> !wb_dat_o[5])
      else $error("cause bit 5 reads one");

   // Main scenarios
   c_start: cover property ($rose(cpu_run_o) && pc_load_o);
   c_irq: cover property (irq_push_o);
   c_wdt: cover property (cpu_run_o && wdt_timeout_i);
endmodule : rsc_seq_assertions

bind rsc_seq rsc_seq_assertions u_rsc_seq_assertions (.*);

// ---- dv/rsc_supply_model.sv ----
`timescale 1ns/10ps
module rsc_supply_model (
   input  wire logic clk_i,
   input  wire logic por_req_i,
   input  wire logic brownout_req_i,
   input  wire logic lp_req_i,
   input  wire logic pin_hold_i,
   output logic      por_o,
   output logic      brownout_o,
   output logic      lp_o,
   output logic      pin_n_o,
   output logic      osc_tick_o
);
   logic [1:0] div_r = 2'h0;

   // Monitors follow requests; pin has a pull-up when not held
   assign por_o      = por_req_i;
   assign brownout_o = brownout_req_i;
   assign lp_o       = lp_req_i;
   assign pin_n_o    = !pin_hold_i;

   // Crystal runs at a third of the system clock
   always_ff @(posedge clk_i) begin
      div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
   end
   assign osc_tick_o = (div_r == 2'h2);
endmodule : rsc_supply_model

// ---- dv/rsc_seq_bench.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("mismatch %0t: %h vs %h", $time, g, e); end end
module rsc_seq_bench
   import rsc_pkg::*;
;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        por_i, brownout_i, low_power_brownout_detector_i, external_reset_pin_n_i, osc_tick_i;
   logic        wdt_timeout_i, clrwdt_i, sleep_enter_i, irq_wake_i, global_irq_enable_i, insn_done_i;
   logic        soft_reset_i, stack_over_i, stack_under_i, core_reset_o, cpu_run_o, pc_load_o, irq_push_o;
   logic [15:0] pc_value_o;
   logic [8:0]  ev;
   logic        por_req, brownout_req, lp_req, pin_hold;
   logic [7:0]  rd;
   logic [7:0]  cexp [5] = '{8'h1b, 8'h9f, 8'h5f, 8'h17, 8'h0f};
   int          kev  [5] = '{1, 2, 3, 7, 0};
   int          err_count = 0;
   int          n_compared = 0;
   int          n;

   // Core event pulses
   assign {clrwdt_i, insn_done_i, irq_wake_i, sleep_enter_i} = {ev[8], ev[6:4]};
   assign {stack_under_i, stack_over_i, soft_reset_i, wdt_timeout_i} = ev[3:0];

   initial clk_i = 1'b0;
   always #20 clk_i = ~clk_i;

   rsc_seq #(.MS_DIV(10), .POWER_UP_COUNT(4), .OSC_START_COUNT(8)) u_rsc_seq (.*);
   rsc_supply_model u_rsc_supply_model (.clk_i(clk_i), .por_req_i(por_req), .brownout_req_i(brownout_req),
      .lp_req_i(lp_req), .pin_hold_i(pin_hold | ev[7]), .por_o(por_i), .brownout_o(brownout_i),
      .lp_o(low_power_brownout_detector_i), .pin_n_o(external_reset_pin_n_i), .osc_tick_o(osc_tick_i));

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // One classic cycle, held until ack is sampled
   task automatic wb_io(input logic we, input logic [3:0] adr, input logic [7:0] wd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h0, wd};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb_io

   task automatic chk(input logic [3:0] adr, input logic [7:0] e);
      wb_io(1'b0, adr, 8'h00);
      `CHK(rd, e)
   endtask : chk

   task automatic pulse(input int k);
      @(posedge clk_i);
      ev <= 9'h1 << k;
      @(posedge clk_i);
      ev <= 9'h0;
   endtask : pulse

   // Wait for execution to resume, cycles waited in n
   task automatic wait_run(input logic ld);
      #1;
      for (n = 0; n < 300 && cpu_run_o !== 1'b1; n++) begin
         @(posedge clk_i);
         #1;
      end
      `CHK(cpu_run_o, 1'b1)
      `CHK(pc_load_o, ld)
   endtask : wait_run

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      report_and_stop();
   end

   // Test sequence
   initial begin
      {rst_i, por_req, pin_hold, global_irq_enable_i} <= 4'hf;
      {wb_cyc_i, wb_stb_i, wb_we_i, brownout_req, lp_req} <= 5'h0;
      {wb_adr_i, wb_dat_i, ev, wb_sel_i} <= {4'h0, 32'h0, 9'h0, 4'hf};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      `CHK(core_reset_o, 1'b1)
      repeat (3) @(posedge clk_i);
      por_req <= 1'b0;
      do wb_io(1'b0, REG_SEQ, 8'h00); while (rd[3:0] !== 4'h3);
      `CHK(rd[5:4], 2'b11)
      `CHK(cpu_run_o, 1'b0)
      chk(REG_CAUSE, 8'h1c);
      chk(REG_STATUS, 8'h18);
      chk(REG_CONFIG, 8'h0f);
      chk(4'h2, 8'h00);
      @(posedge clk_i);
      pin_hold <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (pc_load_o !== 1'b1 && n < 40);
      `CHK(n, 11)
      wb_io(1'b1, REG_CAUSE, 8'hff);
      chk(REG_CAUSE, 8'hdf);
      wb_io(1'b1, REG_STATUS, 8'hff);
      chk(REG_STATUS, 8'h18);
      for (int i = 0; i < 5; i++) begin
         wb_io(1'b1, REG_CAUSE, 8'h1f);
         pulse(kev[i]);
         chk(REG_CAUSE, cexp[i]);
         chk(REG_STATUS, (i == 4) ? 8'h08 : 8'h18);
         wait_run(1'b1);
      end
      pulse(8);
      chk(REG_STATUS, 8'h18);
      wb_io(1'b1, REG_CONFIG, 8'h07);
      pulse(2);
      pulse(3);
      #1;
      `CHK(cpu_run_o, 1'b1)
      chk(REG_CAUSE, 8'h0f);
      wb_io(1'b1, REG_CONFIG, 8'h0f);
      for (int i = 0; i < 2; i++) begin
         wb_io(1'b1, REG_CAUSE, 8'h1f);
         @(posedge clk_i);
         {lp_req, brownout_req} <= i[0] ? 2'b10 : 2'b01;
         repeat (3) @(posedge clk_i);
         {lp_req, brownout_req} <= 2'b00;
         wait_run(1'b1);
         `CHK(n >= 72, 1'b1)
         chk(REG_CAUSE, 8'h1e);
         chk(REG_STATUS, 8'h18);
      end
      // Interrupt wake without start-up timer
      wb_io(1'b1, REG_CONFIG, 8'h0b);
      pulse(4);
      chk(REG_STATUS, 8'h10);
      pulse(5);
      wait_run(1'b0);
      chk(REG_STATUS, 8'h10);
      pulse(6);
      #1;
      `CHK({pc_load_o, irq_push_o, pc_value_o}, {2'b11, PC_IRQ_VEC})
      // Watchdog wake through the start-up timer
      wb_io(1'b1, REG_CONFIG, 8'h0f);
      pulse(4);
      pulse(0);
      wait_run(1'b0);
      chk(REG_STATUS, 8'h00);
      chk(REG_CAUSE, 8'h1e);
      // Pin reset while asleep, then pin function disabled
      wb_io(1'b1, REG_CAUSE, 8'h1f);
      pulse(4);
      pulse(7);
      chk(REG_CAUSE, 8'h17);
      chk(REG_STATUS, 8'h10);
      wait_run(1'b1);
      wb_io(1'b1, REG_CONFIG, 8'h0d);
      pulse(7);
      #1;
      `CHK(cpu_run_o, 1'b1)
      chk(REG_CAUSE, 8'h17);
      report_and_stop();
   end
endmodule : rsc_seq_bench
